// file: rtl/mfpc_top.sv
// Purpose: Six multi-function pins with mode registers on classic Wishbone
// Assumes: Fault, watchdog and auxiliary alarm levels come from logic on mclk
// Notes: Byte registers sit in data bits 7:0 at word address offset*4
`timescale 1ns/100ps
`default_nettype none
`include "mfpc_defs.svh"
module mfpc_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [11:0] overCross,
    input wire logic [11:0] underCross,
    input wire logic [11:0] earlyCross,
    input wire logic watchdogOutLow,
    input wire logic auxAlarmLow,
    input wire logic [5:0] pinIn,
    output var mfpc_pkg::mfpc_pin_drive_type pinDrive,
    output var mfpc_pkg::mfpc_func_in_type funcIn
);
    logic [7:0] cfgA_q, cfgB_q, cfgC_q, outData_q, alarmSel_q;
    logic [11:0] alarmMaskA, alarmMaskB;
    logic anyFaultLow_q, alarmALow_q, alarmBLow_q;
    logic [2:0] mode [6];
    logic [5:0] level, cellOut, cellOe;
    logic [7:0] regIdx;
    logic req;
    logic [7:0] rdByte;
    // --------------------------------
    // Mode field unpacking
    // --------------------------------
    assign mode[0] = cfgA_q[2:0];
    assign mode[1] = cfgA_q[5:3];
    assign mode[2] = {cfgB_q[0], cfgA_q[7:6]};
    assign mode[3] = cfgB_q[3:1];
    assign mode[4] = cfgB_q[6:4];
    assign mode[5] = {cfgC_q[1:0], cfgB_q[7]};
    // --------------------------------
    // Wishbone slave
    // --------------------------------
    assign regIdx = {2'h0, wb_adr_i[7:2]};
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always_comb begin
        case (regIdx)
            `MFPC_OFS_CFG_A: rdByte = cfgA_q;
            `MFPC_OFS_CFG_B: rdByte = cfgB_q;
            `MFPC_OFS_CFG_C: rdByte = cfgC_q & `MFPC_CFG_C_MASK;
            `MFPC_OFS_OUT_DATA: rdByte = outData_q & `MFPC_IO_MASK;
            `MFPC_OFS_IN_DATA: rdByte = {2'h0, level};
            `MFPC_OFS_ALARM_SEL: rdByte = alarmSel_q;
            default: rdByte = 8'h00;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? {24'h00_0000, rdByte} : 32'h0000_0000;
        end
    end
    // reserved codes are stored as written; affected pins stay undriven
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfgA_q <= `MFPC_RST_CFG;
            cfgB_q <= `MFPC_RST_CFG;
            cfgC_q <= `MFPC_RST_CFG;
            outData_q <= `MFPC_RST_OUT;
            alarmSel_q <= `MFPC_RST_SEL;
        end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i[9:8] == 2'h0) begin
            case (regIdx)
                `MFPC_OFS_CFG_A: cfgA_q <= wb_dat_i[7:0];
                `MFPC_OFS_CFG_B: cfgB_q <= wb_dat_i[7:0];
                `MFPC_OFS_CFG_C: cfgC_q <= wb_dat_i[7:0] & `MFPC_CFG_C_MASK;
                `MFPC_OFS_OUT_DATA: outData_q <= wb_dat_i[7:0] & `MFPC_IO_MASK;
                `MFPC_OFS_ALARM_SEL: alarmSel_q <= wb_dat_i[7:0];
                default: cfgA_q <= cfgA_q;
            endcase
        end
    end
    // --------------------------------
    // Alarm generation
    // --------------------------------
    assign alarmMaskA = {12{alarmSel_q[0]}};
    assign alarmMaskB = {12{alarmSel_q[4]}};
    always_ff @(posedge mclk) begin
        if (reset) begin
            anyFaultLow_q <= 1'b1;
            alarmALow_q <= 1'b1;
            alarmBLow_q <= 1'b1;
        end else begin
            anyFaultLow_q <= ~(|(overCross | underCross | earlyCross));
            alarmALow_q <= ~(|(alarmMaskA & ((overCross & {12{alarmSel_q[1]}})
                | (underCross & {12{alarmSel_q[2]}}) | (earlyCross & {12{alarmSel_q[3]}}))));
            alarmBLow_q <= ~(|(alarmMaskB & ((overCross & {12{alarmSel_q[5]}})
                | (underCross & {12{alarmSel_q[6]}}) | (earlyCross & {12{alarmSel_q[7]}}))));
        end
    end
    // --------------------------------
    // Pin cells
    // --------------------------------
    for (genvar i = 0; i < 6; i++) begin : gPin
        mfpc_pin_cell uCell (
            .mclk(mclk),
            .reset(reset),
            .mode(mode[i]),
            .outData(outData_q[i]),
            .alarmLow(i < 4 ? anyFaultLow_q : (i == 4 ? alarmALow_q : alarmBLow_q)),
            .wdogLow(watchdogOutLow),
            .auxLow(auxAlarmLow),
            .pinIn(pinIn[i]),
            .isPinSix(i == 5),
            .pinOut(cellOut[i]),
            .pinOe(cellOe[i]),
            .pinLevel(level[i])
        );
    end
    assign pinDrive = {cellOut, cellOe};
    // --------------------------------
    // Input functions
    // --------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            funcIn <= '0;
        end else begin
            funcIn.trackSense1 <= (mode[0] == 3'h0) & level[0];
            funcIn.trackSense2 <= (mode[1] == 3'h0) & level[1];
            funcIn.trackSense3 <= (mode[2] == 3'h0) & level[2];
            funcIn.trackSense4 <= (mode[3] == 3'h0) & level[3];
            funcIn.marginDisable <= (mode[5] == 3'h0) & level[5];
            funcIn.manualReset <= (mode[3] == 3'h7) & level[3];
            funcIn.watchdogInput <= (mode[4] == 3'h7) & level[4];
        end
    end
    // input-only code 101 leaves the driver off and still reads the level
    a_ack_one_cycle: assert property (@(posedge mclk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_anyfault_low: assert property (@(posedge mclk) disable iff (reset)
        (|overCross) |=> !anyFaultLow_q)
        else $error("any-fault not asserted");
    a_pp_drives: assert property (@(posedge mclk) disable iff (reset)
        (mode[0] == 3'h1) && $stable(mode[0]) |=> cellOe[0] && cellOut[0] == $past(outData_q[0]))
        else $error("push-pull pin not driven");
    a_inonly_quiet: assert property (@(posedge mclk) disable iff (reset)
        (mode[1] == 3'h5) |=> !cellOe[1])
        else $error("input-only pin driven");
    a_cfg_c_reserved: assert property (@(posedge mclk) disable iff (reset)
        cfgC_q[7:2] == 6'h00)
        else $error("reserved bits set");
endmodule // mfpc_top
`default_nettype wire

// file: rtl/mfpc_defs.svh
// Purpose: Offsets, field positions and reset values for the multi-function pin block
// Assumes: Included by the top design module only
// Notes: Offsets are register indices; the bus address is index times four
// Summary of operation
// - Byte A: pin1 [2:0], pin2 [5:3], pin3 [7:6]
// - Byte B: pin3 high [0], pin4 [3:1], pin5 [6:4]
// - Pin6 low B[7], high C[1:0]; C[7:2] reserved
// - Code 000: tracking sense pins1-4, margin pin6
// - 001 push-pull, 010 open-drain, 101 input-only
// - 011/100: any-fault or dedicated alarm outputs
// - 110 pin6 watchdog output; 111 pin5 watchdog input
// - 111 pin4 manual reset; pin6 auxiliary alarm
// - Output data byte drives; input byte readable
// - Any-fault outputs active low on any crossing
// - Dedicated alarm asserts on any selected crossing
`ifndef MFPC_DEFS_SVH
`define MFPC_DEFS_SVH
`define MFPC_OFS_CFG_A 8'h1C
`define MFPC_OFS_CFG_B 8'h1D
`define MFPC_OFS_CFG_C 8'h1E
`define MFPC_OFS_OUT_DATA 8'h1A
`define MFPC_OFS_IN_DATA 8'h1B
`define MFPC_OFS_ALARM_SEL 8'h20
`define MFPC_RST_CFG 8'h00
`define MFPC_RST_OUT 8'h00
`define MFPC_RST_SEL 8'h00
`define MFPC_CFG_C_MASK 8'h03
`define MFPC_IO_MASK 8'h3F
`endif

// file: rtl/mfpc_pkg.sv
// Purpose: Types for the multi-function pin block
// Assumes: Nothing
// Notes: Mode codes follow the pin function table
package mfpc_pkg;
    typedef enum logic [2:0] {
        MODE_SENSE = 3'h0,
        MODE_PP_IO = 3'h1,
        MODE_OD_IO = 3'h2,
        MODE_PP_ALARM = 3'h3,
        MODE_OD_ALARM = 3'h4,
        MODE_IN_ONLY = 3'h5,
        MODE_SPECIAL_A = 3'h6,
        MODE_SPECIAL_B = 3'h7
    } mfpc_mode_type;
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } mfpc_pin_drive_type;
    typedef struct packed {
        logic trackSense1;
        logic trackSense2;
        logic trackSense3;
        logic trackSense4;
        logic marginDisable;
        logic manualReset;
        logic watchdogInput;
    } mfpc_func_in_type;
endpackage

// file: rtl/mfpc_pin_cell.sv
// Purpose: One multi-function pin: driver select and input sync
// Assumes: Pin input is asynchronous to mclk
// Notes: Three-flop sync, change accepted when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module mfpc_pin_cell (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [2:0] mode,
    input wire logic outData,
    input wire logic alarmLow,
    input wire logic wdogLow,
    input wire logic auxLow,
    input wire logic pinIn,
    input wire logic isPinSix,
    output logic pinOut,
    output logic pinOe,
    output logic pinLevel
);
    logic s1_q, s2_q, s3_q;
    logic lvl_q;
    logic drvOut, drvOe;
    // --------------------------------
    // Input synchroniser
    // --------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end
    assign pinLevel = lvl_q;
    // --------------------------------
    // Driver select
    // --------------------------------
    always_comb begin
        drvOut = 1'b0;
        drvOe = 1'b0;
        case (mfpc_pkg::mfpc_mode_type'(mode))
            mfpc_pkg::MODE_PP_IO: begin
                drvOut = outData;
                drvOe = 1'b1;
            end
            mfpc_pkg::MODE_OD_IO: begin
                drvOe = ~outData;
            end
            mfpc_pkg::MODE_PP_ALARM: begin
                drvOut = alarmLow;
                drvOe = 1'b1;
            end
            mfpc_pkg::MODE_OD_ALARM: begin
                drvOe = ~alarmLow;
            end
            mfpc_pkg::MODE_SPECIAL_A: begin
                drvOe = isPinSix & ~wdogLow;
            end
            mfpc_pkg::MODE_SPECIAL_B: begin
                drvOe = isPinSix & ~auxLow;
            end
            default: begin
                drvOe = 1'b0;
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else begin
            pinOut <= drvOut;
            pinOe <= drvOe;
        end
    end
    a_od_never_high: assert property (@(posedge mclk) disable iff (reset)
        (mode == 3'h2 || mode == 3'h4) |=> !(pinOe && pinOut))
        else $error("open-drain pin drove high");
endmodule // mfpc_pin_cell
`default_nettype wire

// file: test/mfpc_pin_model.sv
// Purpose: Board side of the six multi-function pins
// Assumes: A pull-up on every pin; board logic may drive an undriven pin
// Notes: A pin the block drives always wins over the board
`timescale 1ns/100ps
`default_nettype none
module mfpc_pin_model (
    input wire mfpc_pkg::mfpc_pin_drive_type pinDrive,
    input wire logic [5:0] extEn,
    input wire logic [5:0] extLevel,
    output logic [5:0] pinLevel
);
    // Driven level, else board level, else pull-up
    assign pinLevel = (pinDrive.oe & pinDrive.out) | (~pinDrive.oe & (~extEn | extLevel));
endmodule // mfpc_pin_model
`default_nettype wire

// file: test/mfpc_top_bench.sv
// Purpose: Self-checking bench for the multi-function pin block
// Assumes: Pull-up on every pin; alarm select opened fully, later closed
// Notes: Read data is checked from a queue when ack appears
`timescale 1ns/100ps
`default_nettype none
module mfpc_top_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, wdLow = 1'b1, auxLow = 1'b1;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0, selW = 4'hF;
    logic alarmOn = 1'b1;
    logic [31:0] datI = 32'h00000000, datO, seed = 32'hA0C7;
    logic [11:0] overX = 12'h000, underX = 12'h000, earlyX = 12'h000;
    logic [5:0] extEn = 6'h00, extLv = 6'h00, pinLv;
    logic [5:0] regIdx[5] = '{6'h1C, 6'h1D, 6'h1E, 6'h1A, 6'h20};
    logic [17:0] setups[7] = '{18'h09249, 18'h12492, 18'h1B6DB, 18'h24924, 18'h2DB6D, 18'h01000, 18'h3F76D};
    logic [7:0] expQ[$];
    int numErrors = 0, numChecks = 0, cycles = 0;
    mfpc_pkg::mfpc_pin_drive_type drive;
    mfpc_pkg::mfpc_func_in_type func;
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    mfpc_top dut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .overCross(overX),
        .underCross(underX), .earlyCross(earlyX), .watchdogOutLow(wdLow), .auxAlarmLow(auxLow),
        .pinIn(pinLv), .pinDrive(drive), .funcIn(func));
    mfpc_pin_model board (.pinDrive(drive), .extEn(extEn), .extLevel(extLv), .pinLevel(pinLv));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic completeRun();
        if (numErrors == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] d, input logic [7:0] e);
        int n = 0;
        if (!wr) expQ.push_back(e);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        sel <= selW;
        adr <= {2'b00, idx, 2'b00};
        datI <= {24'h000000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (n == 16) numErrors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic round(input logic [17:0] m);
        logic [31:0] r;
        logic [5:0] eoe, eout, lv;
        logic flt;
        logic fk;
        mfpc_pkg::mfpc_func_in_type ef;
        r = rnd();
        bus(6'h1C, 1'b1, m[7:0], 8'h00);
        bus(6'h1D, 1'b1, m[15:8], 8'h00);
        bus(6'h1E, 1'b1, {r[5:0], m[17:16]}, 8'h00);
        bus(6'h1C, 1'b0, 8'h00, m[7:0]);
        bus(6'h1D, 1'b0, 8'h00, m[15:8]);
        bus(6'h1E, 1'b0, 8'h00, {6'h00, m[17:16]});
        bus(6'h1A, 1'b1, {2'b00, r[13:8]}, 8'h00);
        overX <= (r[22:21] == 2'd0) ? 12'h001 << r[20:17] : 12'h000;
        underX <= (r[22:21] == 2'd1) ? 12'h001 << r[20:17] : 12'h000;
        earlyX <= (r[22:21] == 2'd2) ? 12'h001 << r[20:17] : 12'h000;
        wdLow <= r[23];
        auxLow <= r[24];
        extEn <= r[30:25];
        extLv <= r[5:0] ^ r[31:26];
        repeat (8) @(posedge mclk);
        flt = (r[22:21] != 2'd3) && (r[20:17] < 4'd12);
        for (int k = 0; k < 6; k++) begin
            fk = (k < 4) ? flt : (flt && alarmOn);
            case (m[3*k +: 3])
                3'h1: {eoe[k], eout[k]} = {1'b1, r[8+k]};
                3'h2: {eoe[k], eout[k]} = {~r[8+k], 1'b0};
                3'h3: {eoe[k], eout[k]} = {1'b1, ~fk};
                3'h4: {eoe[k], eout[k]} = {fk, 1'b0};
                3'h6: {eoe[k], eout[k]} = {k == 5 && !wdLow, 1'b0};
                3'h7: {eoe[k], eout[k]} = {k == 5 && !auxLow, 1'b0};
                default: {eoe[k], eout[k]} = 2'b00;
            endcase
            lv[k] = eoe[k] ? eout[k] : (~extEn[k] | extLv[k]);
        end
        ef = {m[2:0] == 3'h0 && lv[0], m[5:3] == 3'h0 && lv[1], m[8:6] == 3'h0 && lv[2], m[11:9] == 3'h0 && lv[3],
            m[17:15] == 3'h0 && lv[5], m[11:9] == 3'h7 && lv[3], m[14:12] == 3'h7 && lv[4]};
        check({20'h00000, drive.oe, drive.out & drive.oe}, {20'h00000, eoe, eout});
        check({25'h0000000, func}, {25'h0000000, ef});
        bus(6'h1B, 1'b0, 8'h00, {2'b00, lv});
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (ack === 1'b1 && we === 1'b0) begin
            check(datO, {24'h000000, expQ.pop_front()});
        end
        if (cycles == 20000) begin
            numErrors++;
            completeRun();
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        foreach (regIdx[i]) bus(regIdx[i], 1'b0, 8'h00, 8'h00);
        bus(6'h3F, 1'b1, 8'hA5, 8'h00);
        bus(6'h3F, 1'b0, 8'h00, 8'h00);
        bus(6'h20, 1'b1, 8'hFF, 8'h00);
        bus(6'h20, 1'b0, 8'h00, 8'hFF);
        // Write without lane zero selected is ignored
        selW = 4'hE;
        bus(6'h20, 1'b1, 8'h00, 8'h00);
        selW = 4'hF;
        bus(6'h20, 1'b0, 8'h00, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            foreach (setups[s]) round(setups[s]);
            round(18'h3FF6D);
            round(18'h35000);
        end
        // Dedicated alarms closed: they never assert
        bus(6'h20, 1'b1, 8'h00, 8'h00);
        alarmOn = 1'b0;
        round(18'h1B6DB);
        round(18'h24924);
        completeRun();
    end
endmodule // mfpc_top_bench
`default_nettype wire
